// >>> design/ifd_pkg.sv
package ifd_pkg;

  // Decode slot count and fusion limits
  localparam int SLOTS_C        = 4;
  localparam int PEAK_INSNS_C   = 5;
  localparam int OTHER_INSNS_C  = 3;
  localparam int STEER_SLOT_C   = 0;
  localparam int FLOW_UOPS_C    = 2;
  localparam int MISP_SAVE_C    = 1;
  localparam int MISP_BASE_C    = 4;

  // Instruction class seen by the decoders
  typedef enum logic [2:0]
  {
    IFD_CLS_OTHER  = 3'h0,
    IFD_CLS_CMP    = 3'h1,
    IFD_CLS_TEST   = 3'h2,
    IFD_CLS_JCC    = 3'h3,
    IFD_CLS_STORE  = 3'h4,
    IFD_CLS_LOADOP = 3'h5,
    IFD_CLS_LOADJMP= 3'h6
  } ifd_cls_type;

  // Operand forms
  typedef enum logic [1:0]
  {
    IFD_OPS_RR = 2'h0,
    IFD_OPS_RI = 2'h1,
    IFD_OPS_RM = 2'h2,
    IFD_OPS_MI = 2'h3
  } ifd_ops_type;

  // Condition codes of a conditional branch
  localparam logic [3:0] CC_A  = 4'h7;
  localparam logic [3:0] CC_AE = 4'h3;
  localparam logic [3:0] CC_E  = 4'h4;
  localparam logic [3:0] CC_BE = 4'h6;
  localparam logic [3:0] CC_B  = 4'h2;
  localparam logic [3:0] CC_NE = 4'h5;
  localparam logic [3:0] CC_L  = 4'hC;
  localparam logic [3:0] CC_GE = 4'hD;
  localparam logic [3:0] CC_LE = 4'hE;
  localparam logic [3:0] CC_G  = 4'hF;

  // One decoded candidate from the front end
  typedef struct packed
  {
    logic        valid;
    ifd_cls_type cls;
    ifd_ops_type ops;
    logic        mem_is_mr;
    logic [3:0]  cc;
    logic        ip_rel;
    logic        has_imm;
    logic        ip_ctrl;
  } ifd_insn_type;

  // One micro-operation handed to rename
  typedef struct packed
  {
    logic        valid;
    ifd_cls_type cls;
    logic        macro_fused;
    logic        micro_fused;
    logic [1:0]  uops;
    logic [2:0]  misp_pen;
    logic [3:0]  cc;
  } ifd_uop_type;

endpackage

// >>> design/ifd_macro_check.sv
`timescale 1ns/1ps
// Decides whether a leading compare/test and the next instruction macro-fuse
module ifd_macro_check
  import ifd_pkg::*;
(
  input  ifd_pkg::ifd_insn_type first_i,
  input  ifd_pkg::ifd_insn_type second_i,
  input  wire logic             enhanced_i,
  input  wire logic             mode64_i,
  output logic                  fuse_o
);

  logic lead_ok;
  logic ops_ok;
  logic cc_ok;
  logic mode_ok;
  logic unsigned_cc;
  logic signed_cc;

  // Condition codes for carry/zero and for signed branches
  always_comb
  begin
    unsigned_cc = (second_i.cc == CC_A) || (second_i.cc == CC_AE) || (second_i.cc == CC_E)
               || (second_i.cc == CC_BE) || (second_i.cc == CC_B) || (second_i.cc == CC_NE);
    signed_cc   = (second_i.cc == CC_L) || (second_i.cc == CC_GE) || (second_i.cc == CC_LE)
               || (second_i.cc == CC_G);
  end

  // Pairing conditions
  always_comb
  begin
    lead_ok = first_i.valid && (first_i.cls == IFD_CLS_CMP || first_i.cls == IFD_CLS_TEST);
    ops_ok  = first_i.ops != IFD_OPS_MI;
    if (first_i.cls == IFD_CLS_TEST)
      cc_ok = 1'b1;
    else
      cc_ok = unsigned_cc || (enhanced_i && signed_cc);
    mode_ok = !mode64_i || enhanced_i;
    fuse_o  = lead_ok && ops_ok && cc_ok && mode_ok
           && second_i.valid && second_i.cls == IFD_CLS_JCC;
  end

endmodule

// >>> design/ifd_micro_check.sv
`timescale 1ns/1ps
// Classifies one instruction for micro-fusion and the steered two-uop flow
module ifd_micro_check
  import ifd_pkg::*;
(
  input  ifd_pkg::ifd_insn_type insn_i,
  output logic                  micro_o,
  output logic                  flow2_o
);

  logic has_mem;
  logic ip_block;

  // Memory-operand forms that fuse, and the pointer-relative exceptions
  always_comb
  begin
    has_mem  = (insn_i.cls == IFD_CLS_STORE)
            || (insn_i.cls == IFD_CLS_LOADOP)
            || (insn_i.cls == IFD_CLS_LOADJMP)
            || ((insn_i.cls == IFD_CLS_CMP || insn_i.cls == IFD_CLS_TEST)
                && (insn_i.ops == IFD_OPS_MI || insn_i.ops == IFD_OPS_RM));
    ip_block = insn_i.ip_rel && (insn_i.has_imm || insn_i.ip_ctrl);
    micro_o  = insn_i.valid && has_mem && !ip_block;
    flow2_o  = insn_i.valid && has_mem && ip_block;
  end

endmodule

// >>> design/ifd_fusion_detector.sv
`timescale 1ns/1ps
module ifd_fusion_detector
  import ifd_pkg::*;
#(
  parameter int SLOTS = ifd_pkg::SLOTS_C
)
(
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        enhanced_i,
  input  wire logic                        mode64_i,
  input  ifd_pkg::ifd_insn_type [SLOTS:0]  insn_i,
  output ifd_pkg::ifd_uop_type [SLOTS-1:0] uop_o,
  output logic [2:0]                       consumed_o,
  output logic [2:0]                       dispatch_o
);

  import ifd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Per-slot fusion checks

  logic [SLOTS-1:0] pair_ok;
  logic [SLOTS:0]   micro_ok;
  logic [SLOTS:0]   flow2;

  // The lookahead slot is classified too: it is taken singly behind a fused pair
  genvar g;
  generate
    for (g = 0; g <= SLOTS; g++)
    begin : g_slot
      if (g < SLOTS)
      begin : g_pair
        ifd_macro_check u_macro
        (
          .first_i    (insn_i[g]),
          .second_i   (insn_i[g+1]),
          .enhanced_i (enhanced_i),
          .mode64_i   (mode64_i),
          .fuse_o     (pair_ok[g])
        );
      end
      ifd_micro_check u_micro
      (
        .insn_i  (insn_i[g]),
        .micro_o (micro_ok[g]),
        .flow2_o (flow2[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed
  {
    ifd_uop_type [SLOTS-1:0] uop;
    logic [2:0]              consumed;
    logic [2:0]              dispatch;
  } ifd_state_type;

  ifd_state_type state_q;
  ifd_state_type state_d;

  // Slot packing: walk candidates in order, fuse at most one pair per cycle
  always_comb
  begin
    int   src;
    int   dst;
    logic pair_used;
    logic stop;
    src       = 0;
    dst       = 0;
    pair_used = 1'b0;
    stop      = 1'b0;
    state_d   = '0;
    for (int k = 0; k < SLOTS; k++)
    begin
      if (!stop && src <= SLOTS && insn_i[src].valid) // pair plus three others reaches the lookahead
      begin
        if (flow2[src] && dst != STEER_SLOT_C)
          stop = 1'b1; // wait until it lands in slot zero
        else if (src < SLOTS && pair_ok[src] && !pair_used)
        begin
          state_d.uop[dst].valid       = 1'b1;
          state_d.uop[dst].cls         = IFD_CLS_JCC;
          state_d.uop[dst].macro_fused = 1'b1;
          state_d.uop[dst].micro_fused = micro_ok[src];
          state_d.uop[dst].uops        = 2'h1;
          state_d.uop[dst].misp_pen    = 3'(MISP_BASE_C - MISP_SAVE_C);
          state_d.uop[dst].cc          = insn_i[src+1].cc;
          pair_used = 1'b1;
          src       = src + 2;
          dst       = dst + 1;
        end
        else
        begin
          state_d.uop[dst].valid       = 1'b1;
          state_d.uop[dst].cls         = insn_i[src].cls;
          state_d.uop[dst].micro_fused = micro_ok[src];
          state_d.uop[dst].uops        = flow2[src] ? 2'(FLOW_UOPS_C) : 2'h1;
          state_d.uop[dst].misp_pen    = 3'(MISP_BASE_C);
          state_d.uop[dst].cc          = insn_i[src].cc;
          src = src + 1;
          dst = dst + 1;
          if (flow2[src-1])
            stop = 1'b1; // Steered flow takes the decode group alone
        end
      end
    end
    state_d.consumed = 3'(src);
    state_d.dispatch = 3'(dst);
    if (reset_i)
      state_d = '0;
  end

  // Register the state
  always_ff @(posedge clk_i)
  begin
    state_q <= state_d;
  end

  assign uop_o      = state_q.uop;
  assign consumed_o = state_q.consumed;
  assign dispatch_o = state_q.dispatch;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_peak;
    @(posedge clk_i) disable iff (reset_i)
    consumed_o <= 3'(PEAK_INSNS_C) && (consumed_o - dispatch_o) <= 3'h1;
  endproperty
  a_peak: assert property (p_peak) else $error("decode group too large");

  property p_pair_one;
    @(posedge clk_i) disable iff (reset_i)
    (pair_ok[0] && insn_i[0].valid && !flow2[0]) |=> uop_o[0].macro_fused && uop_o[0].uops == 2'h1;
  endproperty
  a_pair_one: assert property (p_pair_one) else $error("pair not fused");

  property p_pen;
    @(posedge clk_i) disable iff (reset_i)
    uop_o[0].macro_fused |-> uop_o[0].misp_pen == 3'(MISP_BASE_C - MISP_SAVE_C);
  endproperty
  a_pen: assert property (p_pen) else $error("penalty not reduced");

  property p_no64;
    @(posedge clk_i) disable iff (reset_i)
    (mode64_i && !enhanced_i) |=> !uop_o[0].macro_fused;
  endproperty
  a_no64: assert property (p_no64) else $error("fusion in 64-bit base mode");

  property p_mi;
    @(posedge clk_i) disable iff (reset_i)
    (insn_i[0].valid && insn_i[0].ops == IFD_OPS_MI) |=> !uop_o[0].macro_fused;
  endproperty
  a_mi: assert property (p_mi) else $error("mem-imm fused");

  property p_signed;
    @(posedge clk_i) disable iff (reset_i)
    (!enhanced_i && insn_i[0].cls == IFD_CLS_CMP && insn_i[1].cc == CC_L) |=> !uop_o[0].macro_fused;
  endproperty
  a_signed: assert property (p_signed) else $error("signed fused in base");

  property p_flow_slot;
    @(posedge clk_i) disable iff (reset_i)
    uop_o[1].uops == 2'(FLOW_UOPS_C) |-> 1'b0;
  endproperty
  a_flow_slot: assert property (p_flow_slot) else $error("two-uop flow off slot zero");

  property p_store;
    @(posedge clk_i) disable iff (reset_i)
    (insn_i[0].valid && insn_i[0].cls == IFD_CLS_STORE && !insn_i[0].ip_rel) |=> uop_o[0].micro_fused;
  endproperty
  a_store: assert property (p_store) else $error("store not micro-fused");

endmodule

// >>> sim/ifd_rename_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Rename-side sink: counts the uops it takes and the macro-fused pairs
module ifd_rename_model
  import ifd_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  input  ifd_pkg::ifd_uop_type [SLOTS_C-1:0] uop_i,
  output int                                 uop_cnt_o,
  output int                                 fused_cnt_o
);
  import ifd_pkg::*;

  int taken;
  int fused;

  // Count the valid and the macro-fused uops of this cycle
  always_comb
  begin
    taken = 0;
    fused = 0;
    for (int i = 0; i < SLOTS_C; i++)
    begin
      if (uop_i[i].valid === 1'b1)
      begin
        taken = taken + 1;
        if (uop_i[i].macro_fused === 1'b1)
          fused = fused + 1;
      end
    end
  end

  // Take every valid uop each cycle, no backpressure
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      uop_cnt_o   <= 0;
      fused_cnt_o <= 0;
    end
    else
    begin
      uop_cnt_o   <= uop_cnt_o + taken;
      fused_cnt_o <= fused_cnt_o + fused;
    end
  end
endmodule

// >>> sim/ifd_fusion_detector_tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ifd_fusion_detector_tb_top;
  import ifd_pkg::*;

  logic                     clk_i;
  logic                     reset_i;
  logic                     enhanced_i;
  logic                     mode64_i;
  ifd_insn_type [SLOTS_C:0] insn_i;
  ifd_uop_type [SLOTS_C-1:0] uop_o;
  logic [2:0]               consumed_o;
  logic [2:0]               dispatch_o;
  int                       uop_cnt;
  int                       fused_cnt;
  int                       error_cnt;
  int                       n_compared;
  int                       exp_fused;
  int                       exp_uops;
  ifd_insn_type             oth;

  ifd_fusion_detector ifd_fusion_detector_inst (.clk_i(clk_i), .reset_i(reset_i), .enhanced_i(enhanced_i),
    .mode64_i(mode64_i), .insn_i(insn_i), .uop_o(uop_o), .consumed_o(consumed_o), .dispatch_o(dispatch_o));
  ifd_rename_model ifd_rename_model_inst (.clk_i(clk_i), .reset_i(reset_i), .uop_i(uop_o),
    .uop_cnt_o(uop_cnt), .fused_cnt_o(fused_cnt));

  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers: build a candidate, apply one group, compare
  function automatic ifd_insn_type mk(input ifd_cls_type c, input ifd_ops_type o, input logic [3:0] cc,
                                      input logic [2:0] f);
    return '{1'b1, c, o, 1'b0, cc, f[2], f[1], f[0]};
  endfunction

  task automatic run(input ifd_insn_type [4:0] v);
    insn_i = v;
    @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pair(input ifd_cls_type c, input ifd_ops_type o, input logic [3:0] cc,
                      input logic enh, input logic m64, input logic exp);
    enhanced_i = enh;
    mode64_i   = m64;
    run({oth, oth, oth, mk(IFD_CLS_JCC, IFD_OPS_RR, cc, 3'h0), mk(c, o, 4'h0, 3'h0)});
    if (exp)
      exp_fused++;
    exp_uops = exp_uops + 4;
    chk(8'(uop_o[0].macro_fused), 8'(exp));
    chk(8'(consumed_o), exp ? 8'h05 : 8'h04);
    chk(8'(dispatch_o), 8'h04);
  endtask

  task automatic single(input ifd_insn_type v, input logic exp);
    run({oth, oth, oth, oth, v});
    exp_uops = exp_uops + (exp ? 4 : 1);
    chk(8'(uop_o[0].micro_fused), 8'(exp));
    chk(8'(dispatch_o), exp ? 8'h04 : 8'h01);
    if (!exp)
      chk(8'(uop_o[0].uops), 8'h02);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_walk;
    enhanced_i = 1'b0;
    mode64_i   = 1'b0;
    run({oth, oth, mk(IFD_CLS_STORE, IFD_OPS_RM, 4'h0, 3'h0), mk(IFD_CLS_JCC, IFD_OPS_RR, CC_E, 3'h0),
         mk(IFD_CLS_CMP, IFD_OPS_RR, 4'h0, 3'h0)});
    exp_fused++;
    exp_uops = exp_uops + 4;
    chk(8'(uop_o[0].cls), 8'(IFD_CLS_JCC));
    chk(8'(uop_o[0].cc), 8'(CC_E));
    chk(8'(uop_o[0].uops), 8'h01);
    chk(8'(uop_o[0].misp_pen), 8'(MISP_BASE_C - MISP_SAVE_C));
    chk(8'(uop_o[1].micro_fused), 8'h01);
    chk(8'(consumed_o), 8'(PEAK_INSNS_C));
    chk(8'(dispatch_o), 8'(OTHER_INSNS_C + 1));
  endtask

  task automatic t_cond;
    logic [3:0] ccs [10];
    ccs = '{CC_A, CC_AE, CC_E, CC_BE, CC_B, CC_NE, CC_L, CC_GE, CC_LE, CC_G};
    for (int i = 0; i < 10; i++)
    begin
      pair(IFD_CLS_CMP, IFD_OPS_RR, ccs[i], 1'b0, 1'b0, i < 6);
      pair(IFD_CLS_CMP, IFD_OPS_RR, ccs[i], 1'b1, 1'b0, 1'b1);
      pair(IFD_CLS_TEST, IFD_OPS_RR, ccs[i], 1'b0, 1'b0, 1'b1);
    end
  endtask

  task automatic t_leader;
    pair(IFD_CLS_CMP, IFD_OPS_RI, CC_E, 1'b0, 1'b0, 1'b1);
    pair(IFD_CLS_TEST, IFD_OPS_RM, CC_NE, 1'b0, 1'b0, 1'b1);
    pair(IFD_CLS_CMP, IFD_OPS_MI, CC_E, 1'b1, 1'b0, 1'b0);
    pair(IFD_CLS_TEST, IFD_OPS_MI, CC_E, 1'b1, 1'b0, 1'b0);
    pair(IFD_CLS_OTHER, IFD_OPS_RR, CC_E, 1'b1, 1'b0, 1'b0);
    pair(IFD_CLS_STORE, IFD_OPS_RM, CC_E, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic t_mode;
    pair(IFD_CLS_CMP, IFD_OPS_RR, CC_E, 1'b0, 1'b1, 1'b0);
    pair(IFD_CLS_TEST, IFD_OPS_RR, CC_E, 1'b1, 1'b1, 1'b1);
    pair(IFD_CLS_CMP, IFD_OPS_RR, CC_G, 1'b1, 1'b1, 1'b1);
  endtask

  task automatic t_micro;
    single(mk(IFD_CLS_STORE, IFD_OPS_MI, 4'h0, 3'h0), 1'b1);
    single(mk(IFD_CLS_LOADOP, IFD_OPS_RM, 4'h0, 3'h0), 1'b1);
    single(mk(IFD_CLS_LOADJMP, IFD_OPS_RM, 4'h0, 3'h0), 1'b1);
    single(mk(IFD_CLS_CMP, IFD_OPS_MI, 4'h0, 3'h0), 1'b1);
    single(mk(IFD_CLS_STORE, IFD_OPS_MI, 4'h0, 3'h6), 1'b0);
    single(mk(IFD_CLS_LOADJMP, IFD_OPS_RM, 4'h0, 3'h5), 1'b0);
  endtask

  task automatic t_steer;
    run({oth, oth, mk(IFD_CLS_CMP, IFD_OPS_MI, 4'h0, 3'h6), oth, oth});
    exp_uops = exp_uops + 2;
    chk(8'(consumed_o), 8'h02);
    chk(8'(dispatch_o), 8'h02);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    #20000;
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    error_cnt  = 0;
    n_compared = 0;
    exp_fused  = 0;
    exp_uops   = 0;
    insn_i     = '0;
    enhanced_i = 1'b0;
    mode64_i   = 1'b0;
    reset_i    = 1'b1;
    oth        = mk(IFD_CLS_OTHER, IFD_OPS_RR, 4'h0, 3'h0);
    repeat (3) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    @(posedge clk_i);
    #1;
    chk(8'(dispatch_o), 8'h00);
    t_walk();
    t_cond();
    t_leader();
    t_mode();
    t_micro();
    t_steer();
    insn_i = '0;
    repeat (3) @(posedge clk_i);
    #1;
    chk(8'(fused_cnt), 8'(exp_fused));
    chk(8'(uop_cnt), 8'(exp_uops));
    end_of_test();
  end
endmodule
